// file: common/bsad_pkg.sv
package bsad_pkg;

    localparam int BSAD_PC_W_MIN = 12;
    localparam int BSAD_PC_W_MID = 13;
    localparam int BSAD_PC_W_MAX = 14;
    localparam int BSAD_PTR_W    = 16;
    localparam int BSAD_WORD_BITS_NARROW = 5;
    localparam int BSAD_WORD_BITS_WIDE   = 6;

    // boot start per fuse pair, index is {hi, lo}
    localparam logic [3:0][13:0] BSAD_BOOT_START_12 = {14'h0F80, 14'h0F00, 14'h0E00, 14'h0C00};
    localparam logic [3:0][13:0] BSAD_BOOT_START_13 = {14'h1F80, 14'h1F00, 14'h1E00, 14'h1C00};
    localparam logic [3:0][13:0] BSAD_BOOT_START_14 = {14'h3F00, 14'h3E00, 14'h3C00, 14'h3800};
    localparam logic [13:0] BSAD_STALL_START_12 = 14'h0C00;
    localparam logic [13:0] BSAD_STALL_START_13 = 14'h1C00;
    localparam logic [13:0] BSAD_STALL_START_14 = 14'h3800;

    localparam int          BSAD_AV_ADDR_W   = 3;
    localparam logic [2:0]  BSAD_REG_POINTER = 3'h0;
    localparam logic [2:0]  BSAD_REG_COMMAND = 3'h1;
    localparam logic [2:0]  BSAD_REG_STATUS  = 3'h2;
    localparam logic [2:0]  BSAD_REG_LAYOUT  = 3'h3;
    localparam logic [2:0]  BSAD_REG_ERRORS  = 3'h4;
    localparam logic [15:0] BSAD_POINTER_RST = 16'h0000;
    localparam int          BSAD_CMD_DATA_LSB = 16;
    localparam int          BSAD_LAYOUT_STALL_LSB = 16;
    localparam int          BSAD_STAT_BUSY    = 0;
    localparam int          BSAD_STAT_REGION  = 1;
    localparam int          BSAD_STAT_HALT    = 2;
    localparam int          BSAD_STAT_FUSE_LO = 3;
    localparam int          BSAD_STAT_FUSE_HI = 4;
    localparam int          BSAD_STAT_BOOT    = 5;
    localparam int          BSAD_ERR_Z0       = 0;
    localparam int          BSAD_ERR_WORD     = 1;
    localparam int          BSAD_ERR_REFUSED  = 2;

    typedef enum logic [2:0]
    {
        BSAD_CMD_NONE     = 3'h0,
        BSAD_CMD_BUF_LOAD = 3'h1,
        BSAD_CMD_ERASE    = 3'h2,
        BSAD_CMD_WRITE    = 3'h3,
        BSAD_CMD_REENABLE = 3'h4
    } bsad_cmd_t;

    typedef enum logic [1:0]
    {
        BSAD_ST_IDLE   = 2'h0,
        BSAD_ST_RUN    = 2'h1,
        BSAD_ST_FINISH = 2'h3
    } bsad_state_t;

    function automatic logic [13:0] bsad_boot_start(input int w, input logic [1:0] fuse);
        case (w)
            BSAD_PC_W_MIN: return BSAD_BOOT_START_12[fuse];
            BSAD_PC_W_MID: return BSAD_BOOT_START_13[fuse];
            default:       return BSAD_BOOT_START_14[fuse];
        endcase
    endfunction : bsad_boot_start

    function automatic logic [13:0] bsad_stall_start(input int w);
        case (w)
            BSAD_PC_W_MIN: return BSAD_STALL_START_12;
            BSAD_PC_W_MID: return BSAD_STALL_START_13;
            default:       return BSAD_STALL_START_14;
        endcase
    endfunction : bsad_stall_start

    function automatic int bsad_word_bits(input int w);
        return (w == BSAD_PC_W_MIN) ? BSAD_WORD_BITS_NARROW : BSAD_WORD_BITS_WIDE;
    endfunction : bsad_word_bits

    // pointer bit 0 and bits above the counter width drop out
    function automatic logic [13:0] bsad_word_addr(input int w, input logic [15:0] z);
        logic [13:0] a;
        a = z[14:1];
        for (int i = 0; i < 14; i++)
        begin
            if (i >= w)
            begin
                a[i] = 1'b0;
            end
        end
        return a;
    endfunction : bsad_word_addr

    function automatic logic bsad_in_stalled(input int w, input logic [13:0] addr);
        return addr >= bsad_stall_start(w);
    endfunction : bsad_in_stalled

endpackage : bsad_pkg

// file: common/bsad_dec_if.sv
`timescale 1ns/10ps
interface bsad_dec_if;
    logic [13:0] word_addr;
    logic [1:0]  fuse;
    logic [13:0] boot_start;
    logic [13:0] app_end;
    logic        in_stalled;
    logic        in_boot;
    logic [7:0]  page;
    logic [5:0]  word;

    modport user    (output word_addr, fuse, input boot_start, app_end, in_stalled, in_boot, page, word);
    modport decoder (input word_addr, fuse, output boot_start, app_end, in_stalled, in_boot, page, word);
endinterface : bsad_dec_if

// file: verilog/bsad_decode.sv
`timescale 1ns/10ps
module bsad_decode
    import bsad_pkg::*;
#(
    parameter int PC_W = 14
)
(
    bsad_dec_if.decoder dec
);

    // purely combinational so classification follows the pointer at once
    always_comb
    begin
        int pb;
        pb             = bsad_word_bits(PC_W);
        dec.boot_start = bsad_boot_start(PC_W, dec.fuse);
        dec.app_end    = dec.boot_start - 14'h1;
        dec.in_boot    = dec.word_addr > dec.app_end;
        dec.in_stalled = bsad_in_stalled(PC_W, dec.word_addr);
        dec.page       = 8'(dec.word_addr >> pb);
        dec.word       = 6'(dec.word_addr & ((14'h1 << pb) - 14'h1));
    end

endmodule : bsad_decode

// file: verilog/bsad_top.sv
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
// What this block does
// - 12-bit: fuse 11,10,01,00 gives boot start F80,F00,E00,C00; application ends below.
// - 12-bit: 000-BFF reads concurrently, C00-FFF stalls, whatever the fuse.
// - 13-bit: fuse 11..00 gives boot start 1F80,1F00,1E00,1C00.
// - 13-bit: 0000-1BFF reads concurrently, 1C00-1FFF stalls.
// - 14-bit: fuse 11..00 gives boot start 3F00,3E00,3C00,3800.
// - 14-bit: 0000-37FF reads concurrently, 3800-3FFF stalls.
// - 12-bit: 32-word pages, page from pointer 12:6, word from 5:1.
// - 13-bit: 64-word pages, page from pointer 13:7, word from 6:1.
// - 14-bit: 64-word pages, page from pointer 14:7, word from 6:1.
// - pointer bits above the page field are ignored.
// - pointer bit 0 zero for stores; byte select for program reads.
// - page field picks page for erase and write; word field picks buffer word.
// - erase or write into concurrent region sets busy flag blocking its reads.
// - erase or write into stalled region halts the core throughout.
module bsad_top
    import bsad_pkg::*;
#(
    parameter int PC_W = 14
)
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        CE,
    input  wire logic [2:0]  AV_ADDRESS,
    input  wire logic        AV_READ,
    input  wire logic        AV_WRITE,
    input  wire logic [31:0] AV_WRITEDATA,
    input  wire logic [3:0]  AV_BYTEENABLE,
    output logic      [31:0] AV_READDATA,
    output logic             AV_WAITREQUEST,
    input  wire logic        BOOT_SIZE_SEL_HI,
    input  wire logic        BOOT_SIZE_SEL_LO,
    input  wire logic        LOAD_REQ,
    input  wire logic [15:0] LOAD_POINTER,
    output logic      [13:0] LOAD_WORD_ADDR,
    output logic             LOAD_BYTE_SEL,
    output logic             LOAD_GRANT,
    output logic             LOAD_STALL,
    input  wire logic        FLASH_DONE,
    output logic             FLASH_ERASE,
    output logic             FLASH_WRITE,
    output logic             FLASH_BUF_LOAD,
    output logic      [7:0]  FLASH_PAGE,
    output logic      [5:0]  FLASH_WORD,
    output logic      [15:0] FLASH_DATA,
    output logic             CORE_HALT,
    output logic      [13:0] BOOT_RESET_ADDR
);

    if (PC_W < BSAD_PC_W_MIN || PC_W > BSAD_PC_W_MAX)
    begin : g_bad_width
        $error("bsad_top: PC_W must be 12, 13 or 14");
    end

    bsad_state_t  state_reg;
    bsad_state_t  state_next;
    logic [15:0]  pointer_reg;
    logic [1:0]   fuse_reg;
    logic         region_busy_reg;
    logic         halt_reg;
    logic [2:0]   err_reg;
    logic         wait_reg;
    logic [31:0]  rdata_reg;
    logic [31:0]  rdata_next;

    bsad_dec_if dec_bus ();

    bsad_decode #(
        .PC_W (PC_W)
    ) u_decode (
        .dec (dec_bus)
    );

    assign dec_bus.word_addr = bsad_word_addr(PC_W, pointer_reg);
    assign dec_bus.fuse      = fuse_reg;

    logic      av_req;
    logic      av_take;
    logic      cmd_take;
    bsad_cmd_t cmd;
    logic      idle;
    logic      go_erase;
    logic      go_write;
    logic      go_prog;
    logic      go_buf;
    logic      go_reenable;
    logic      refuse;
    logic      word_bad;
    logic [13:0] load_addr;
    logic        load_stalled;

    assign av_req       = AV_READ || AV_WRITE;
    assign av_take      = CE && av_req && !wait_reg;
    assign cmd_take     = av_take && AV_WRITE && AV_ADDRESS == BSAD_REG_COMMAND && AV_BYTEENABLE[0];
    assign cmd          = bsad_cmd_t'(AV_WRITEDATA[2:0]);
    assign idle         = state_reg == BSAD_ST_IDLE;
    assign word_bad     = dec_bus.word != 6'h00;
    assign go_erase     = cmd_take && idle && cmd == BSAD_CMD_ERASE;
    assign go_write     = cmd_take && idle && cmd == BSAD_CMD_WRITE && !word_bad;
    assign go_prog      = go_erase || go_write;
    assign go_buf       = cmd_take && idle && cmd == BSAD_CMD_BUF_LOAD;
    assign go_reenable  = cmd_take && idle && cmd == BSAD_CMD_REENABLE;
    // any command other than BSAD_CMD_NONE is turned away during an operation
    assign refuse       = cmd_take && cmd != BSAD_CMD_NONE && (!idle || (cmd == BSAD_CMD_WRITE && word_bad));
    assign load_addr    = bsad_word_addr(PC_W, LOAD_POINTER);
    assign load_stalled = bsad_in_stalled(PC_W, load_addr);

    // fuse pair is a strap, caught while reset is held
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            fuse_reg <= {BOOT_SIZE_SEL_HI, BOOT_SIZE_SEL_LO};
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            BOOT_RESET_ADDR <= 14'h0000;
        end
        else if (CE)
        begin
            BOOT_RESET_ADDR <= dec_bus.boot_start;
        end
    end

    // bus slave: every access waits exactly one cycle while CE is high
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            wait_reg <= 1'b1;
        end
        else if (CE)
        begin
            wait_reg <= !(av_req && wait_reg);
        end
    end

    always_comb
    begin
        rdata_next = 32'h0000_0000;
        case (AV_ADDRESS)
            BSAD_REG_POINTER: rdata_next[15:0] = pointer_reg;
            BSAD_REG_STATUS:
            begin
                rdata_next[BSAD_STAT_BUSY]    = !idle;
                rdata_next[BSAD_STAT_REGION]  = region_busy_reg;
                rdata_next[BSAD_STAT_HALT]    = halt_reg;
                rdata_next[BSAD_STAT_FUSE_LO] = fuse_reg[0];
                rdata_next[BSAD_STAT_FUSE_HI] = fuse_reg[1];
                rdata_next[BSAD_STAT_BOOT]    = dec_bus.in_boot;
            end
            BSAD_REG_LAYOUT:
            begin
                rdata_next[13:0] = dec_bus.boot_start;
                rdata_next[BSAD_LAYOUT_STALL_LSB +: 14] = bsad_stall_start(PC_W);
            end
            BSAD_REG_ERRORS:  rdata_next[2:0] = err_reg;
            default:          rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            rdata_reg <= 32'h0000_0000;
        end
        else if (CE && av_req && wait_reg)
        begin
            rdata_reg <= rdata_next;
        end
    end

    assign AV_READDATA    = rdata_reg;
    assign AV_WAITREQUEST = wait_reg;

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            pointer_reg <= BSAD_POINTER_RST;
        end
        else if (av_take && AV_WRITE && AV_ADDRESS == BSAD_REG_POINTER)
        begin
            if (AV_BYTEENABLE[0])
            begin
                pointer_reg[7:0] <= AV_WRITEDATA[7:0];
            end
            if (AV_BYTEENABLE[1])
            begin
                pointer_reg[15:8] <= AV_WRITEDATA[15:8];
            end
        end
    end

    // errors are write-one-to-clear; a new event wins over the clear
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            err_reg <= 3'h0;
        end
        else if (CE)
        begin
            for (int i = 0; i < 3; i++)
            begin
                if (av_take && AV_WRITE && AV_ADDRESS == BSAD_REG_ERRORS && AV_BYTEENABLE[0] && AV_WRITEDATA[i])
                begin
                    err_reg[i] <= 1'b0;
                end
            end
            if ((go_prog || go_buf) && pointer_reg[0])
            begin
                err_reg[BSAD_ERR_Z0] <= 1'b1;
            end
            if (cmd_take && cmd == BSAD_CMD_WRITE && word_bad)
            begin
                err_reg[BSAD_ERR_WORD] <= 1'b1;
            end
            if (refuse)
            begin
                err_reg[BSAD_ERR_REFUSED] <= 1'b1;
            end
        end
    end

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            BSAD_ST_IDLE:
            begin
                if (go_prog)
                begin
                    state_next = BSAD_ST_RUN;
                end
            end
            BSAD_ST_RUN:
            begin
                if (FLASH_DONE)
                begin
                    state_next = BSAD_ST_FINISH;
                end
            end
            BSAD_ST_FINISH: state_next = BSAD_ST_IDLE;
            default:        state_next = BSAD_ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            state_reg <= BSAD_ST_IDLE;
        end
        else if (CE)
        begin
            state_reg <= state_next;
        end
    end

    // flash strobes, one cycle each
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            FLASH_ERASE    <= 1'b0;
            FLASH_WRITE    <= 1'b0;
            FLASH_BUF_LOAD <= 1'b0;
            FLASH_PAGE     <= 8'h00;
            FLASH_WORD     <= 6'h00;
            FLASH_DATA     <= 16'h0000;
        end
        else if (CE)
        begin
            FLASH_ERASE    <= go_erase;
            FLASH_WRITE    <= go_write;
            FLASH_BUF_LOAD <= go_buf;
            if (go_prog)
            begin
                FLASH_PAGE <= dec_bus.page;
            end
            if (go_buf)
            begin
                FLASH_WORD <= dec_bus.word;
                FLASH_DATA <= AV_WRITEDATA[BSAD_CMD_DATA_LSB +: 16];
            end
        end
    end

    // a buffer load also drops the busy flag, as a re-enable would
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            region_busy_reg <= 1'b0;
        end
        else if (CE)
        begin
            if (go_prog && !dec_bus.in_stalled)
            begin
                region_busy_reg <= 1'b1;
            end
            else if (go_reenable || go_buf)
            begin
                region_busy_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            halt_reg  <= 1'b0;
            CORE_HALT <= 1'b0;
        end
        else if (CE)
        begin
            if (go_prog && dec_bus.in_stalled)
            begin
                halt_reg  <= 1'b1;
                CORE_HALT <= 1'b1;
            end
            else if (state_reg == BSAD_ST_RUN && FLASH_DONE)
            begin
                halt_reg  <= 1'b0;
                CORE_HALT <= 1'b0;
            end
        end
    end

    // program-memory reads from the core, answered next cycle
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            LOAD_WORD_ADDR <= 14'h0000;
            LOAD_BYTE_SEL  <= 1'b0;
            LOAD_GRANT     <= 1'b0;
            LOAD_STALL     <= 1'b0;
        end
        else if (CE)
        begin
            LOAD_GRANT <= 1'b0;
            LOAD_STALL <= 1'b0;
            if (LOAD_REQ)
            begin
                LOAD_WORD_ADDR <= load_addr;
                LOAD_BYTE_SEL  <= LOAD_POINTER[0];
                LOAD_STALL     <= region_busy_reg && !load_stalled;
                LOAD_GRANT     <= !(region_busy_reg && !load_stalled);
            end
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence s_launch_stalled;
        CE && go_prog && dec_bus.in_stalled;
    endsequence

    sequence s_launch_concurrent;
        CE && go_prog && !dec_bus.in_stalled;
    endsequence

    boot_addr_a: assert property (CE && !RST |=> BOOT_RESET_ADDR == $past(bsad_boot_start(PC_W, fuse_reg)))
        else $error("boot reset address does not follow the fuse pair");
    stall_grant_a: assert property (CE && LOAD_REQ && load_addr >= bsad_stall_start(PC_W) |=> LOAD_GRANT)
        else $error("read of stalled region was not granted");
    busy_block_a: assert property (CE && LOAD_REQ && region_busy_reg && !load_stalled |=> LOAD_STALL && !LOAD_GRANT)
        else $error("concurrent region readable while busy");
    byte_sel_a: assert property (CE && LOAD_REQ |=> LOAD_BYTE_SEL == $past(LOAD_POINTER[0]))
        else $error("byte select does not follow pointer bit 0");
    high_bits_a: assert property (CE && LOAD_REQ |=>
        LOAD_WORD_ADDR == ($past(LOAD_POINTER[14:1]) & ((14'h1 << PC_W) - 14'h1)))
        else $error("ignored pointer bits reached the word address");
    halt_hold_a: assert property (s_launch_stalled |=> CORE_HALT && state_reg == BSAD_ST_RUN)
        else $error("core not halted for stalled region operation");
    halt_stay_a: assert property (CORE_HALT && !(CE && FLASH_DONE) |=> CORE_HALT)
        else $error("core released before the operation ended");
    busy_set_a: assert property (s_launch_concurrent |=> region_busy_reg ##1 region_busy_reg || !CE)
        else $error("busy flag not set by concurrent region operation");
    page_field_a: assert property (CE && go_prog |=> FLASH_PAGE == $past(dec_bus.page) && (FLASH_ERASE || FLASH_WRITE))
        else $error("flash page does not follow the page field");
    buf_word_a: assert property (CE && go_buf |=> FLASH_BUF_LOAD && FLASH_WORD == $past(dec_bus.word))
        else $error("buffer word does not follow the word field");
    write_word_a: assert property (cmd_take && idle && cmd == BSAD_CMD_WRITE && word_bad |=> !FLASH_WRITE && err_reg[BSAD_ERR_WORD])
        else $error("page write with nonzero word field was launched");
    page_split_a: assert property (CE && go_prog |=> FLASH_PAGE == 8'($past(dec_bus.word_addr) >> bsad_word_bits(PC_W)))
        else $error("page field taken from the wrong pointer bits");
    bus_answer_a: assert property (CE && av_req && AV_WAITREQUEST |=> !AV_WAITREQUEST)
        else $error("bus access not answered after one wait cycle");

endmodule : bsad_top

// file: test/bsad_flash_model.sv
`timescale 1ns/10ps
// flash macro stand-in: one done pulse, lat cycles after each launch
module bsad_flash_model
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       go,
    input  wire logic [7:0] lat,
    output logic            done
);
    logic [7:0] cnt_reg;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt_reg <= 8'h00;
            done    <= 1'b0;
        end
        else
        begin
            done <= (cnt_reg == 8'h01);
            if (go)
            begin
                cnt_reg <= lat;
            end
            else if (cnt_reg != 8'h00)
            begin
                cnt_reg <= cnt_reg - 8'h01;
            end
        end
    end
endmodule : bsad_flash_model

// file: test/tb.sv
`timescale 1ns/10ps
module tb import bsad_pkg::*;;
    logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, rd = 1'b0, wr = 1'b0, lreq = 1'b0, fh = 1'b0, fl = 1'b0;
    logic [2:0]  adr = 3'h0;
    logic [3:0]  be = 4'hF;
    logic [31:0] wd = 32'h0, rdat, q;
    logic [15:0] lptr = 16'h0, fdat;
    logic [7:0]  lat = 8'h02, pg;
    logic [13:0] la, bra;
    logic [5:0]  fwd;
    logic        wreq, bs, lg, ls, fd, fe, fw, fb, halt;
    int          n_fail = 0, samples_checked = 0, cyc = 0;

    always #10 clk = ~clk;

    bsad_top #(.PC_W(14)) dut_u (.CLK(clk), .RST(rst), .CE(ce), .AV_ADDRESS(adr), .AV_READ(rd), .AV_WRITE(wr),
        .AV_WRITEDATA(wd), .AV_BYTEENABLE(be), .AV_READDATA(rdat), .AV_WAITREQUEST(wreq),
        .BOOT_SIZE_SEL_HI(fh), .BOOT_SIZE_SEL_LO(fl), .LOAD_REQ(lreq), .LOAD_POINTER(lptr),
        .LOAD_WORD_ADDR(la), .LOAD_BYTE_SEL(bs), .LOAD_GRANT(lg), .LOAD_STALL(ls), .FLASH_DONE(fd),
        .FLASH_ERASE(fe), .FLASH_WRITE(fw), .FLASH_BUF_LOAD(fb), .FLASH_PAGE(pg), .FLASH_WORD(fwd),
        .FLASH_DATA(fdat), .CORE_HALT(halt), .BOOT_RESET_ADDR(bra));

    bsad_flash_model fm_u (.clk(clk), .rst(rst), .go(fe | fw), .lat(lat), .done(fd));

    // whole run is a few hundred cycles
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            n_fail++;
            wrap_up();
        end
    end

    task automatic wrap_up;
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
        begin
            $display("Test passed");
        end
        else
        begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
            n_fail++;
        end
    endtask : chk

    // held until a rising edge samples waitrequest low, released at that edge
    task automatic av(input logic w, input logic [2:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd  <= d;
        wr  <= w;
        rd  <= ~w;
        do
        begin
            @(posedge clk);
        end
        while (wreq !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : av

    task automatic cmd(input logic [2:0] c, input logic [15:0] d);
        av(1'b1, BSAD_REG_COMMAND, {d, 13'h0, c});
    endtask : cmd

    task automatic ld(input logic [15:0] p, input logic [13:0] ea, input logic g);
        @(posedge clk);
        lreq <= 1'b1;
        lptr <= p;
        @(posedge clk);
        lreq <= 1'b0;
        @(negedge clk);
        chk("ld_addr", ea, la);
        chk("ld_bsel", p[0], bs);
        chk("ld_grant", {g, ~g}, {lg, ls});
    endtask : ld

    task automatic wait_idle;
        int i;
        i = 0;
        do
        begin
            av(1'b0, BSAD_REG_STATUS, 32'h0);
            i++;
        end
        while (q[0] !== 1'b0 && i < 100);
        chk("idle", 0, q[0]);
    endtask : wait_idle

    task automatic t_boot;
        logic [13:0] bt [4];
        bt = '{14'h3800, 14'h3C00, 14'h3E00, 14'h3F00};
        for (int f = 0; f < 4; f++)
        begin
            @(posedge clk);
            {fh, fl} <= f[1:0];
            rst <= 1'b1;
            repeat (5) @(posedge clk);
            rst <= 1'b0;
            @(posedge clk);
            @(negedge clk);
            chk("boot_addr", bt[f], bra);
            av(1'b0, BSAD_REG_LAYOUT, 32'h0);
            chk("stall_start", 14'h3800, q[29:16]);
            chk("layout_boot", bt[f], q[13:0]);
            av(1'b0, BSAD_REG_STATUS, 32'h0);
            chk("fuse", f[1:0], q[4:3]);
        end
    endtask : t_boot

    task automatic t_stall;
        lat <= 8'd20;
        av(1'b1, BSAD_REG_POINTER, 32'h0000F800);
        cmd(BSAD_CMD_ERASE, 16'h0);
        @(negedge clk);
        chk("erase", 1, fe);
        chk("page", 8'hF0, pg);
        chk("halt", 1, halt);
        repeat (10) @(negedge clk);
        chk("halt_mid", 1, halt);
        wait_idle();
        chk("halt_end", 0, halt);
        chk("no_flag", 0, q[1]);
    endtask : t_stall

    task automatic t_conc;
        lat <= 8'd40;
        av(1'b1, BSAD_REG_POINTER, 32'h00000800);
        cmd(BSAD_CMD_ERASE, 16'h0);
        @(negedge clk);
        chk("halt_conc", 0, halt);
        ld(16'h0002, 14'h0001, 1'b0);
        ld(16'h6FFE, 14'h37FF, 1'b0);
        ld(16'h7000, 14'h3800, 1'b1);
        cmd(BSAD_CMD_BUF_LOAD, 16'h1234);
        av(1'b0, BSAD_REG_ERRORS, 32'h0);
        chk("refused", 3'h4, q[2:0]);
        av(1'b1, BSAD_REG_ERRORS, 32'h7);
        av(1'b0, BSAD_REG_ERRORS, 32'h0);
        chk("w1c", 3'h0, q[2:0]);
        wait_idle();
        chk("flag_held", 1, q[1]);
        cmd(BSAD_CMD_REENABLE, 16'h0);
        av(1'b0, BSAD_REG_STATUS, 32'h0);
        chk("flag_clr", 0, q[1]);
        ld(16'h0002, 14'h0001, 1'b1);
    endtask : t_conc

    task automatic t_buf;
        av(1'b1, BSAD_REG_POINTER, 32'h0000807F);
        cmd(BSAD_CMD_BUF_LOAD, 16'hA5C3);
        @(negedge clk);
        chk("buf_load", 1, fb);
        chk("buf_word", 6'h3F, fwd);
        chk("buf_data", 16'hA5C3, fdat);
        av(1'b0, BSAD_REG_ERRORS, 32'h0);
        chk("z0_flag", 3'h1, q[2:0]);
        av(1'b1, BSAD_REG_ERRORS, 32'h7);
    endtask : t_buf

    task automatic t_pwrite;
        lat <= 8'd2;
        av(1'b1, BSAD_REG_POINTER, 32'h00000802);
        cmd(BSAD_CMD_WRITE, 16'h0);
        @(negedge clk);
        chk("no_write", 0, fw);
        av(1'b0, BSAD_REG_ERRORS, 32'h0);
        chk("word_err", 3'h6, q[2:0]);
        av(1'b1, BSAD_REG_ERRORS, 32'h7);
        av(1'b1, BSAD_REG_POINTER, 32'h00000800);
        cmd(BSAD_CMD_WRITE, 16'h0);
        @(negedge clk);
        chk("write", 1, fw);
        chk("wr_page", 8'h10, pg);
        wait_idle();
        chk("wr_flag", 1, q[1]);
        cmd(BSAD_CMD_REENABLE, 16'h0);
    endtask : t_pwrite

    task automatic t_map;
        av(1'b0, 3'h5, 32'h0);
        chk("unmapped", 32'h0, q);
        av(1'b1, BSAD_REG_POINTER, 32'h0000BEEF);
        av(1'b0, BSAD_REG_POINTER, 32'h0);
        chk("pointer", 16'hBEEF, q[15:0]);
        av(1'b1, BSAD_REG_POINTER, 32'h00007E00);
        av(1'b0, BSAD_REG_STATUS, 32'h0);
        chk("in_boot", 1, q[5]);
        av(1'b1, BSAD_REG_POINTER, 32'h00007DFE);
        av(1'b0, BSAD_REG_STATUS, 32'h0);
        chk("in_app", 0, q[5]);
    endtask : t_map

    // bus access stalls while the enable is low and completes once it returns
    task automatic t_ce;
        @(posedge clk);
        ce <= 1'b0;
        fork
            av(1'b1, BSAD_REG_POINTER, 32'h00001234);
            begin
                repeat (4) @(posedge clk);
                chk("ce_freeze", 1, wreq);
                ce <= 1'b1;
            end
        join
        av(1'b0, BSAD_REG_POINTER, 32'h0);
        chk("ce_resume", 16'h1234, q[15:0]);
    endtask : t_ce

    initial
    begin
        t_boot();
        t_stall();
        t_conc();
        t_buf();
        t_pwrite();
        t_map();
        t_ce();
        wrap_up();
    end
endmodule : tb
